// ===== src/piw_top.sv
`timescale 1ns/100ps
// Operation
// - Pins 0/1 edge or level, pin 2 edge
// - No halt while enabled pin is low
// - Pin 1 flag sets on fall, ISR clears
// - Pin 1 select: 0 level, 1 edge
// - Pin 0 flag sets on fall, ISR clears
// - Pin 0 select: 0 level, 1 edge
// - Pin 2 flag sets on fall, ISR clears
// - Writing FBh clears only pin 2 flag
// - Enabled port pin change sets port flag
// - Writing FDh clears only port flag
// - Flag write 0 clears, 1 keeps
// - Idle wake needs own enable and global
// - Idle wake enters service routine at once
// - Trigger must outlast one clock sample
// - Enabled pin or timer 3 wakes halt
// - After halt, one instruction before service
// - Halt pin service needs global and over 64 clocks low
// - Port change wakes halt, service needs global
// - Power bits enter halt or idle
// - Pin enable wakes halt regardless global
// - Port wake uses per-pin enables only (code: halt wake only; idle wake also needs port IE and global)
module piw_top (
    input wire MCLK,
    input wire RST_N,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    output logic [7:0] REG_RDATA,
    input wire EXT_PIN_ZERO,
    input wire EXT_PIN_ONE,
    input wire EXT_PIN_TWO,
    input wire [7:0] PORT0_PINS,
    input wire [7:0] PORT1_PINS,
    input wire [7:0] PORT2_PINS,
    input wire [7:0] PORT3_PINS,
    input wire GLOBAL_INT_ENABLE,
    input wire PIN0_INT_ENABLE,
    input wire PIN1_INT_ENABLE,
    input wire PIN2_INT_ENABLE,
    input wire PORT_CHANGE_INT_ENABLE,
    input wire TIMER3_INT_ENABLE,
    input wire TIMER3_IRQ,
    input wire OTHER_WAKE_REQ,
    input wire ISR_ENTER_PIN0,
    input wire ISR_ENTER_PIN1,
    input wire ISR_ENTER_PIN2,
    input wire ISR_ENTER_PORT,
    input wire INSTR_DONE,
    output logic IRQ_PIN0,
    output logic IRQ_PIN1,
    output logic IRQ_PIN2,
    output logic IRQ_PORT,
    output logic IDLE_MODE,
    output logic HALT_MODE,
    output logic WAKE,
    output logic DEFER_ISR
);
    localparam int N = piw_pkg::PIW_NPINS;

    piw_pkg::piw_pwr_e pwr_q;
    logic smod_q;
    logic [1:0] gf_q;
    logic [3:0] tmr_bits_q;
    logic [1:0] trig_sel_q;
    logic [N-1:0] edge_flag_q;
    logic port_flag_q;
    logic port_drop_q;
    logic [31:0] wake_en_q;
    logic [N-1:0] judge_q;
    logic defer_q;
    logic wake_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;

    logic [N-1:0] ext_lvl;
    logic [N-1:0] ext_fall;
    logic [31:0] port_chg;
    logic [N-1:0] pin_low;
    logic [N-1:0] pin_en;
    logic [N-1:0] pin_req;
    logic [N-1:0] long_low;
    logic [N-1:0] isr_clr;
    logic [N-1:0] sw_wr;
    logic [N-1:0] sw_val;
    logic [N-1:0] judge_end;
    logic [N-1:0] drop_pin;
    logic wr_pwr;
    logic wr_tec;
    logic wr_flg;
    logic port_evt;
    logic sleep_blocked;
    logic raw_any;
    logic idle_wake;
    logic halt_wake;
    logic halt_woke;
    logic irq_gate;

    // Pin synchronisers, one stage of history for the edge compare
    piw_sync_edge #(
        .W(N)
    ) u_ext_sync (
        .clk(MCLK),
        .rst_n(RST_N),
        .din({EXT_PIN_TWO, EXT_PIN_ONE, EXT_PIN_ZERO}),
        .level(ext_lvl),
        .fall(ext_fall),
        .change()
    );

    piw_sync_edge #(
        .W(piw_pkg::PIW_NPORT)
    ) u_port_sync (
        .clk(MCLK),
        .rst_n(RST_N),
        .din({PORT3_PINS, PORT2_PINS, PORT1_PINS, PORT0_PINS}),
        .level(),
        .fall(),
        .change(port_chg)
    );

    // Low-width qualifiers used only when judging a halt wake
    generate
        for (genvar i = 0; i < N; i++) begin : g_width
            piw_width_cnt u_width (
                .clk(MCLK),
                .rst_n(RST_N),
                .low(pin_low[i]),
                .long_low(long_low[i])
            );
        end
    endgenerate

    // Register port write decode
    assign wr_pwr = REG_WR && (REG_ADDR == piw_pkg::PIW_ADDR_PWR);
    assign wr_tec = REG_WR && (REG_ADDR == piw_pkg::PIW_ADDR_TEC);
    assign wr_flg = REG_WR && (REG_ADDR == piw_pkg::PIW_ADDR_FLG);

    // Per-pin views
    assign pin_low = ~ext_lvl;
    assign pin_en = {PIN2_INT_ENABLE, PIN1_INT_ENABLE, PIN0_INT_ENABLE};
    assign isr_clr = {ISR_ENTER_PIN2, ISR_ENTER_PIN1, ISR_ENTER_PIN0};

    // Trigger source per pin; pin 2 has no level mode
    always_comb begin
        for (int i = 0; i < N - 1; i++) begin
            pin_req[i] = trig_sel_q[i] ? edge_flag_q[i] : pin_low[i];
        end
        pin_req[N-1] = edge_flag_q[N-1];
    end

    // Port change event through per-pin wake enables, not the port IE
    assign port_evt = |(port_chg & wake_en_q);

    // Halt entry is refused while an enabled pin sits low
    assign sleep_blocked = |(pin_low & pin_en);

    // Enabled and globally enabled requests wake idle
    assign raw_any = GLOBAL_INT_ENABLE && (|(pin_req & pin_en & ~judge_q)
                     || (port_flag_q && PORT_CHANGE_INT_ENABLE));
    assign idle_wake = raw_any || OTHER_WAKE_REQ;

    // Halt wakes on enabled pin low, port change or timer 3, global enable ignored
    assign halt_wake = (|(pin_low & pin_en))
                       || port_evt
                       || (TIMER3_IRQ && TIMER3_INT_ENABLE);
    assign halt_woke = (pwr_q == piw_pkg::PIW_HALT) && halt_wake;

    // Power state; power-down has priority when both bits are written, unless halt entry is refused, then idle is entered
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            pwr_q <= piw_pkg::PIW_RUN;
        end else begin
            unique case (pwr_q)
                piw_pkg::PIW_RUN: begin
                    if (wr_pwr && REG_WDATA[piw_pkg::PIW_PWR_DOWN] && !sleep_blocked) begin
                        pwr_q <= piw_pkg::PIW_HALT;
                    end else if (wr_pwr && REG_WDATA[piw_pkg::PIW_PWR_IDLE]) begin
                        pwr_q <= piw_pkg::PIW_IDLE;
                    end
                end
                piw_pkg::PIW_IDLE: begin
                    if (idle_wake) begin
                        pwr_q <= piw_pkg::PIW_RUN;
                    end
                end
                piw_pkg::PIW_HALT: begin
                    if (halt_wake) begin
                        pwr_q <= piw_pkg::PIW_RUN;
                    end
                end
                default: begin
                    pwr_q <= piw_pkg::PIW_RUN;
                end
            endcase
        end
    end

    // Wake pulse, one cycle long, in the first cycle after leaving either sleep state
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= halt_woke || ((pwr_q == piw_pkg::PIW_IDLE) && idle_wake);
        end
    end

    // After halt the core runs one instruction before any service
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            defer_q <= 1'b0;
        end else if (halt_woke) begin
            defer_q <= 1'b1;
        end else if (INSTR_DONE) begin
            defer_q <= 1'b0;
        end
    end

    // Judge each waking pin: service only if held over 64 clocks with global enable
    assign judge_end = judge_q & (~pin_low | long_low);
    assign drop_pin = judge_end & ~(long_low & {N{GLOBAL_INT_ENABLE}});

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            judge_q <= '0;
        end else if (halt_woke) begin
            judge_q <= pin_low & pin_en;
        end else begin
            judge_q <= judge_q & ~judge_end;
        end
    end

    // Software writes into the edge flags
    always_comb begin
        sw_wr[0] = wr_tec;
        sw_val[0] = REG_WDATA[piw_pkg::PIW_TEC_EF0];
        sw_wr[1] = wr_tec;
        sw_val[1] = REG_WDATA[piw_pkg::PIW_TEC_EF1];
        sw_wr[2] = wr_flg && !REG_WDATA[piw_pkg::PIW_FLG_EF2];
        sw_val[2] = 1'b0;
    end

    // Edge flags: a fall wins over any clear in the same cycle
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            edge_flag_q <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                if (ext_fall[i]) begin
                    edge_flag_q[i] <= 1'b1;
                end else if (isr_clr[i] || drop_pin[i]) begin
                    edge_flag_q[i] <= 1'b0;
                end else if (sw_wr[i]) begin
                    edge_flag_q[i] <= sw_val[i];
                end
            end
        end
    end

    // Port wake without global enable must not lead into the service routine
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            port_drop_q <= 1'b0;
        end else begin
            port_drop_q <= halt_woke && port_evt && !GLOBAL_INT_ENABLE;
        end
    end

    // Port change flag; new change wins over clears
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            port_flag_q <= 1'b0;
        end else if (port_evt) begin
            port_flag_q <= 1'b1;
        end else if (ISR_ENTER_PORT || port_drop_q) begin
            port_flag_q <= 1'b0;
        end else if (wr_flg && !REG_WDATA[piw_pkg::PIW_FLG_PORT]) begin
            port_flag_q <= 1'b0;
        end
    end

    // Plain storage: trigger selects, timer bits, power misc bits
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            trig_sel_q <= '0;
            tmr_bits_q <= piw_pkg::PIW_RST_NIB;
        end else if (wr_tec) begin
            trig_sel_q[0] <= REG_WDATA[piw_pkg::PIW_TEC_TS0];
            trig_sel_q[1] <= REG_WDATA[piw_pkg::PIW_TEC_TS1];
            tmr_bits_q <= REG_WDATA[piw_pkg::PIW_TEC_TMR_HI:piw_pkg::PIW_TEC_TMR_LO];
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            smod_q <= 1'b0;
            gf_q <= '0;
        end else if (wr_pwr) begin
            smod_q <= REG_WDATA[piw_pkg::PIW_PWR_SMOD];
            gf_q <= REG_WDATA[piw_pkg::PIW_PWR_GF1:piw_pkg::PIW_PWR_GF0];
        end
    end

    // Per-pin wake enables, one byte per port
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            wake_en_q <= piw_pkg::PIW_RST_WORD;
        end else if (REG_WR) begin
            unique case (REG_ADDR)
                piw_pkg::PIW_ADDR_P0WK: wake_en_q[7:0] <= REG_WDATA;
                piw_pkg::PIW_ADDR_P1WK: wake_en_q[15:8] <= REG_WDATA;
                piw_pkg::PIW_ADDR_P2WK: wake_en_q[23:16] <= REG_WDATA;
                piw_pkg::PIW_ADDR_P3WK: wake_en_q[31:24] <= REG_WDATA;
                default: wake_en_q <= wake_en_q;
            endcase
        end
    end

    // Read mux; unmapped addresses and reserved bits read zero
    always_comb begin
        rdata_d = piw_pkg::PIW_RST_BYTE;
        unique case (REG_ADDR)
            piw_pkg::PIW_ADDR_PWR: begin
                rdata_d[piw_pkg::PIW_PWR_SMOD] = smod_q;
                rdata_d[piw_pkg::PIW_PWR_GF1:piw_pkg::PIW_PWR_GF0] = gf_q;
                rdata_d[piw_pkg::PIW_PWR_DOWN] = pwr_q == piw_pkg::PIW_HALT;
                rdata_d[piw_pkg::PIW_PWR_IDLE] = pwr_q == piw_pkg::PIW_IDLE;
            end
            piw_pkg::PIW_ADDR_TEC: begin
                rdata_d[piw_pkg::PIW_TEC_TMR_HI:piw_pkg::PIW_TEC_TMR_LO] = tmr_bits_q;
                rdata_d[piw_pkg::PIW_TEC_EF1] = edge_flag_q[1];
                rdata_d[piw_pkg::PIW_TEC_TS1] = trig_sel_q[1];
                rdata_d[piw_pkg::PIW_TEC_EF0] = edge_flag_q[0];
                rdata_d[piw_pkg::PIW_TEC_TS0] = trig_sel_q[0];
            end
            piw_pkg::PIW_ADDR_FLG: begin
                rdata_d[piw_pkg::PIW_FLG_EF2] = edge_flag_q[2];
                rdata_d[piw_pkg::PIW_FLG_PORT] = port_flag_q;
            end
            piw_pkg::PIW_ADDR_P0WK: rdata_d = wake_en_q[7:0];
            piw_pkg::PIW_ADDR_P1WK: rdata_d = wake_en_q[15:8];
            piw_pkg::PIW_ADDR_P2WK: rdata_d = wake_en_q[23:16];
            piw_pkg::PIW_ADDR_P3WK: rdata_d = wake_en_q[31:24];
            default: rdata_d = piw_pkg::PIW_RST_BYTE;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            rdata_q <= piw_pkg::PIW_RST_BYTE;
        end else begin
            rdata_q <= REG_RD ? rdata_d : piw_pkg::PIW_RST_BYTE;
        end
    end

    // Requests to the core: held off while asleep, deferred or judging
    assign irq_gate = GLOBAL_INT_ENABLE && (pwr_q == piw_pkg::PIW_RUN) && !defer_q;
    assign IRQ_PIN0 = irq_gate && pin_en[0] && pin_req[0] && !judge_q[0];
    assign IRQ_PIN1 = irq_gate && pin_en[1] && pin_req[1] && !judge_q[1];
    assign IRQ_PIN2 = irq_gate && pin_en[2] && pin_req[2] && !judge_q[2];
    assign IRQ_PORT = irq_gate && PORT_CHANGE_INT_ENABLE && port_flag_q;

    // Status outputs, all from flip-flops
    assign IDLE_MODE = pwr_q == piw_pkg::PIW_IDLE;
    assign HALT_MODE = pwr_q == piw_pkg::PIW_HALT;
    assign WAKE = wake_q;
    assign DEFER_ISR = defer_q;
    assign REG_RDATA = rdata_q;
endmodule

// ===== src/piw_pkg.sv
package piw_pkg;

    // Register addresses on the plain register port
    localparam logic [7:0] PIW_ADDR_PWR = 8'h87;
    localparam logic [7:0] PIW_ADDR_TEC = 8'h88;
    localparam logic [7:0] PIW_ADDR_FLG = 8'h95;
    localparam logic [7:0] PIW_ADDR_P1WK = 8'h96;
    localparam logic [7:0] PIW_ADDR_P0WK = 8'hC5;
    localparam logic [7:0] PIW_ADDR_P2WK = 8'hC6;
    localparam logic [7:0] PIW_ADDR_P3WK = 8'hC7;

    // power_control fields
    localparam int PIW_PWR_IDLE = 0;
    localparam int PIW_PWR_DOWN = 1;
    localparam int PIW_PWR_GF0 = 2;
    localparam int PIW_PWR_GF1 = 3;
    localparam int PIW_PWR_SMOD = 7;

    // timer_and_ext_int_control fields
    localparam int PIW_TEC_TS0 = 0;
    localparam int PIW_TEC_EF0 = 1;
    localparam int PIW_TEC_TS1 = 2;
    localparam int PIW_TEC_EF1 = 3;
    localparam int PIW_TEC_TMR_LO = 4;
    localparam int PIW_TEC_TMR_HI = 7;

    // interrupt_flags fields
    localparam int PIW_FLG_PORT = 1;
    localparam int PIW_FLG_EF2 = 2;

    // Reset values
    localparam logic [7:0] PIW_RST_BYTE = 8'h00;
    localparam logic [3:0] PIW_RST_NIB = 4'h0;
    localparam logic [31:0] PIW_RST_WORD = 32'h0000_0000;

    // Pin count and halt trigger qualification (in system clocks)
    localparam int PIW_NPINS = 3;
    localparam int PIW_NPORT = 32;
    localparam int PIW_CNT_W = 7;
    localparam logic [PIW_CNT_W-1:0] PIW_HALT_TRIG_CLKS = 7'h40;
    localparam logic [PIW_CNT_W-1:0] PIW_CNT_MAX = 7'h7F;

    // Power state, Gray along run-idle and run-halt
    typedef enum logic [1:0] {
        PIW_RUN = 2'h0,
        PIW_IDLE = 2'h1,
        PIW_HALT = 2'h2
    } piw_pwr_e;

endpackage

// ===== src/piw_sync_edge.sv
`timescale 1ns/100ps
module piw_sync_edge #(
    parameter int W = 1
) (
    input wire clk,
    input wire rst_n,
    input wire [W-1:0] din,
    output logic [W-1:0] level,
    output logic [W-1:0] fall,
    output logic [W-1:0] change
);
    logic [W-1:0] meta_q;
    logic [W-1:0] lvl_q;
    logic [W-1:0] prev_q;

    // Two-flop synchroniser plus history; resets high as pins idle high
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '1;
            lvl_q <= '1;
            prev_q <= '1;
        end else begin
            meta_q <= din;
            lvl_q <= meta_q;
            prev_q <= lvl_q;
        end
    end

    // Compare consecutive synced samples, so each edge gives one pulse
    assign level = lvl_q;
    assign fall = prev_q & ~lvl_q;
    assign change = prev_q ^ lvl_q;
endmodule

// ===== src/piw_width_cnt.sv
`timescale 1ns/100ps
module piw_width_cnt (
    input wire clk,
    input wire rst_n,
    input wire low,
    output logic long_low
);
    logic [piw_pkg::PIW_CNT_W-1:0] cnt_q;

    // Counts consecutive low samples, saturating so it never wraps
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!low) begin
            cnt_q <= '0;
        end else if (cnt_q != piw_pkg::PIW_CNT_MAX) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    // Strictly more than the qualifying width
    assign long_low = cnt_q > piw_pkg::PIW_HALT_TRIG_CLKS;
endmodule

// ===== tb/piw_top_props.sv
`timescale 1ns/100ps
module piw_top_props (
    input wire MCLK,
    input wire RST_N,
    input wire [7:0] REG_ADDR,
    input wire [7:0] REG_WDATA,
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_RDATA,
    input wire EXT_PIN_ZERO,
    input wire GLOBAL_INT_ENABLE,
    input wire PIN0_INT_ENABLE,
    input wire PIN1_INT_ENABLE,
    input wire INSTR_DONE,
    input wire IRQ_PIN0,
    input wire IRQ_PIN1,
    input wire IRQ_PIN2,
    input wire IRQ_PORT,
    input wire IDLE_MODE,
    input wire HALT_MODE,
    input wire WAKE,
    input wire DEFER_ISR
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    // Power control write decode
    wire pwr_wr = REG_WR && (REG_ADDR == piw_pkg::PIW_ADDR_PWR);
    wire any_irq = IRQ_PIN0 || IRQ_PIN1 || IRQ_PIN2 || IRQ_PORT;
    // Three samples cover the two-flop synchroniser delay
    sequence s_pin0_held;
        (!EXT_PIN_ZERO && PIN0_INT_ENABLE)[*3];
    endsequence
    sequence s_halt_req;
        pwr_wr && REG_WDATA[piw_pkg::PIW_PWR_DOWN];
    endsequence
    a_rdata_quiet: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data present without a read");
    a_halt_refused: assert property (s_pin0_held ##0 s_halt_req |=> !HALT_MODE)
        else $error("halt entered while enabled pin low");
    a_idle_entry: assert property (pwr_wr && REG_WDATA[0] && !REG_WDATA[1] && !IDLE_MODE
        && !HALT_MODE |=> IDLE_MODE)
        else $error("idle not entered");
    a_modes_apart: assert property (!(IDLE_MODE && HALT_MODE))
        else $error("idle and halt together");
    a_wake_single: assert property (WAKE |=> !WAKE)
        else $error("wake longer than one cycle");
    a_wake_cause: assert property (WAKE |-> ($past(IDLE_MODE) || $past(HALT_MODE))
        && !IDLE_MODE && !HALT_MODE)
        else $error("wake without leaving a sleep mode");
    a_halt_defer: assert property ($fell(HALT_MODE) |-> WAKE && DEFER_ISR)
        else $error("halt exit without deferral");
    a_defer_release: assert property (DEFER_ISR && INSTR_DONE |=> !DEFER_ISR)
        else $error("deferral kept after instruction");
    a_defer_masks: assert property (DEFER_ISR |-> !any_irq)
        else $error("request during deferral");
    a_irq_global: assert property (any_irq |-> GLOBAL_INT_ENABLE)
        else $error("request with global enable clear");
    a_irq_own_en: assert property ((IRQ_PIN0 |-> PIN0_INT_ENABLE)
        and (IRQ_PIN1 |-> PIN1_INT_ENABLE))
        else $error("pin request with its enable clear");
endmodule

// ===== tb/piw_pin_model.sv
`timescale 1ns/100ps
module piw_pin_model (
    input wire clk,
    output logic [2:0] pins,
    output logic [31:0] port
);
    // Idle high, as the pins sit with pull-ups
    initial begin
        pins = 3'h7;
        port = 32'hFFFF_FFFF;
    end
    // Low pulse; a single clock may be missed by the sampler
    task automatic pulse(input int idx, input int width);
        @(posedge clk);
        pins[idx] <= 1'b0;
        repeat (width) @(posedge clk);
        pins[idx] <= 1'b1;
    endtask
    // Level held until changed again
    task automatic set_pin(input int idx, input logic v);
        @(posedge clk);
        pins[idx] <= v;
    endtask
    // One port pin change, any width counts
    task automatic flip(input int b);
        @(posedge clk);
        port[b] <= ~port[b];
    endtask
endmodule

// ===== tb/piw_top_tb_top.sv
`timescale 1ns/100ps
module piw_top_tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic rd_seen = 1'b0;
    logic gie = 1'b0, en0 = 1'b0, en1 = 1'b0, en2 = 1'b0, pce = 1'b0, t3en = 1'b0;
    logic t3 = 1'b0, idone = 1'b0, owr = 1'b0;
    logic [3:0] isr = 4'h0;
    wire [7:0] rdata;
    wire [3:0] irq;
    wire idle, halt, wake, defer;
    wire [2:0] pins;
    wire [31:0] port;
    logic [7:0] exp_q[$];
    logic [7:0] wk[4] = '{piw_pkg::PIW_ADDR_P0WK, piw_pkg::PIW_ADDR_P1WK,
                          piw_pkg::PIW_ADDR_P2WK, piw_pkg::PIW_ADDR_P3WK};
    int n_mismatch = 0, comparisons = 0, cyc = 0, wakes = 0, w0, b;
    int unsigned seed_v;

    always #10 mclk = ~mclk;

    piw_pin_model u_pins (.clk(mclk), .pins(pins), .port(port));

    piw_top u_dut (
        .MCLK(mclk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata),
        .EXT_PIN_ZERO(pins[0]), .EXT_PIN_ONE(pins[1]), .EXT_PIN_TWO(pins[2]),
        .PORT0_PINS(port[7:0]), .PORT1_PINS(port[15:8]),
        .PORT2_PINS(port[23:16]), .PORT3_PINS(port[31:24]),
        .GLOBAL_INT_ENABLE(gie), .PIN0_INT_ENABLE(en0), .PIN1_INT_ENABLE(en1),
        .PIN2_INT_ENABLE(en2), .PORT_CHANGE_INT_ENABLE(pce),
        .TIMER3_INT_ENABLE(t3en), .TIMER3_IRQ(t3), .OTHER_WAKE_REQ(owr),
        .ISR_ENTER_PIN0(isr[0]), .ISR_ENTER_PIN1(isr[1]),
        .ISR_ENTER_PIN2(isr[2]), .ISR_ENTER_PORT(isr[3]), .INSTR_DONE(idone),
        .IRQ_PIN0(irq[0]), .IRQ_PIN1(irq[1]), .IRQ_PIN2(irq[2]), .IRQ_PORT(irq[3]),
        .IDLE_MODE(idle), .HALT_MODE(halt), .WAKE(wake), .DEFER_ISR(defer)
    );

    task summarize();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge mclk) begin
        if (rd_seen)
            chk(rdata, exp_q.pop_front());
        rd_seen <= rd_s;
        if (wake === 1'b1)
            wakes++;
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            summarize();
        end
    end

    // Strobes drop with a spare edge so no task re-enters on the same step
    task wr(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge mclk);
        wr_s <= 1'b0;
        @(posedge mclk);
    endtask

    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge mclk);
        rd_s <= 1'b0;
        @(posedge mclk);
    endtask

    task tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task isr_p(input int i);
        isr[i] <= 1'b1;
        tick(1);
        isr[i] <= 1'b0;
        tick(1);
    endtask

    task instr();
        idone <= 1'b1;
        tick(1);
        idone <= 1'b0;
        tick(1);
    endtask

    task done(input string s);
        $display("test %0s finished", s);
    endtask

    initial begin
        seed_v = $urandom(32'h8f26b70b);
        tick(2);
        rst_n <= 1'b1;
        tick(3);
        // Register defaults and an unmapped read
        rd(8'h88, 8'h00);
        rd(8'h95, 8'h00);
        rd(8'h87, 8'h00);
        rd(8'($urandom_range(127, 0)), 8'h00);
        done("reset");
        // Pin 0 edge mode, pin 1 level mode
        gie <= 1'b1;
        en0 <= 1'b1;
        wr(8'h88, 8'h01);
        u_pins.pulse(0, 4);
        tick(4);
        chk({7'h0, irq[0]}, 8'h01);
        rd(8'h88, 8'h03);
        isr_p(0);
        rd(8'h88, 8'h01);
        u_pins.pulse(1, 4);
        tick(4);
        rd(8'h88, 8'h09);
        en1 <= 1'b1;
        u_pins.set_pin(1, 1'b0);
        tick(4);
        chk({7'h0, irq[1]}, 8'h01);
        gie <= 1'b0;
        tick(1);
        chk({7'h0, irq[1]}, 8'h00);
        u_pins.set_pin(1, 1'b1);
        en1 <= 1'b0;
        gie <= 1'b1;
        tick(4);
        wr(8'h88, 8'h01);
        done("pins");
        // Flag register: pin 2, port change, write-zero clears
        b = $urandom_range(31, 0);
        wr(wk[b / 8], 8'(1 << (b % 8)));
        rd(wk[b / 8], 8'(1 << (b % 8)));
        u_pins.pulse(2, 4);
        u_pins.flip(b ^ 1);
        tick(4);
        rd(8'h95, 8'h04);
        u_pins.flip(b);
        tick(4);
        rd(8'h95, 8'h06);
        en2 <= 1'b1;
        pce <= 1'b1;
        tick(1);
        chk({6'h0, irq[3:2]}, 8'h03);
        en2 <= 1'b0;
        pce <= 1'b0;
        wr(8'h95, 8'hFB);
        rd(8'h95, 8'h02);
        u_pins.pulse(2, 4);
        tick(4);
        wr(8'h95, 8'hFD);
        rd(8'h95, 8'h04);
        wr(8'h95, 8'hFF);
        rd(8'h95, 8'h04);
        isr_p(2);
        rd(8'h95, 8'h00);
        done("flags");
        // Idle: no wake without global enable, then wake and service
        gie <= 1'b0;
        wr(8'h87, 8'h01);
        chk({7'h0, idle}, 8'h01);
        u_pins.pulse(0, 4);
        tick(6);
        chk({7'h0, idle}, 8'h01);
        wr(8'h88, 8'h01);
        w0 = wakes;
        gie <= 1'b1;
        u_pins.pulse(0, 4);
        tick(4);
        chk(8'(wakes - w0), 8'h01);
        chk({6'h0, idle, irq[0]}, 8'h01);
        isr_p(0);
        // The OTHER_WAKE_REQ input wakes idle too
        wr(8'h87, 8'h01);
        chk({7'h0, idle}, 8'h01);
        owr <= 1'b1;
        tick(2);
        owr <= 1'b0;
        chk({7'h0, idle}, 8'h00);
        done("idle");
        // Halt refused while an enabled pin is low
        u_pins.set_pin(0, 1'b0);
        tick(3);
        wr(8'h87, 8'h02);
        chk({7'h0, halt}, 8'h00);
        u_pins.set_pin(0, 1'b1);
        tick(4);
        isr_p(0);
        // Short pulse with global enable clear wakes without service
        gie <= 1'b0;
        wr(8'h87, 8'h02);
        chk({7'h0, halt}, 8'h01);
        rd(8'h87, 8'h02);
        w0 = wakes;
        u_pins.pulse(0, 10);
        tick(3);
        chk({6'h0, halt, defer}, 8'h01);
        chk(8'(wakes - w0), 8'h01);
        instr();
        tick(80);
        rd(8'h88, 8'h01);
        // Long pulse with global enable keeps the flag
        gie <= 1'b1;
        wr(8'h87, 8'h02);
        u_pins.pulse(0, 80);
        tick(4);
        instr();
        rd(8'h88, 8'h03);
        chk({7'h0, irq[0]}, 8'h01);
        isr_p(0);
        done("halt pins");
        // Timer 3 and port change wakes, global enable clear
        gie <= 1'b0;
        t3en <= 1'b1;
        wr(8'h87, 8'h02);
        t3 <= 1'b1;
        tick(3);
        chk({7'h0, halt}, 8'h00);
        t3 <= 1'b0;
        instr();
        wr(8'h87, 8'h02);
        u_pins.flip(b);
        tick(6);
        chk({7'h0, halt}, 8'h00);
        rd(8'h95, 8'h00);
        instr();
        done("halt others");
        tick(2);
        summarize();
    end
endmodule

bind piw_top piw_top_props u_props (
    .MCLK(MCLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .EXT_PIN_ZERO(EXT_PIN_ZERO), .GLOBAL_INT_ENABLE(GLOBAL_INT_ENABLE),
    .PIN0_INT_ENABLE(PIN0_INT_ENABLE), .PIN1_INT_ENABLE(PIN1_INT_ENABLE),
    .INSTR_DONE(INSTR_DONE), .IRQ_PIN0(IRQ_PIN0), .IRQ_PIN1(IRQ_PIN1),
    .IRQ_PIN2(IRQ_PIN2), .IRQ_PORT(IRQ_PORT), .IDLE_MODE(IDLE_MODE),
    .HALT_MODE(HALT_MODE), .WAKE(WAKE), .DEFER_ISR(DEFER_ISR)
);
